// ---- design/bps_pkg.sv ----
/*
 * Shared constants and types of the branch control unit.
 * Assumes a single core clock; every module of the block imports it.
 */
package bps_pkg;
    localparam int BPS_AW = 32;
    localparam int BPS_BTB_ENTRIES = 256;
    localparam int BPS_BTB_WAYS = 4;
    localparam int BPS_RAS_DEPTH = 8;
    localparam int BPS_SPEC_MAX = 4;
    localparam logic [2:0] BPS_PEN_EX = 3'h4;
    localparam logic [2:0] BPS_PEN_WB = 3'h5;
    localparam logic [2:0] BPS_LEVEL_RST = 3'h0;

    typedef enum logic [2:0] {
        BPS_K_NONE = 3'h0,
        BPS_K_JMP = 3'h1,
        BPS_K_JCC = 3'h2,
        BPS_K_CALL = 3'h3,
        BPS_K_RET = 3'h4
    } bps_kind_t;

    typedef enum logic [1:0] {
        BPS_SNT = 2'h0,
        BPS_WNT = 2'h1,
        BPS_WT = 2'h2,
        BPS_ST = 2'h3
    } bps_ctr_t;

    typedef enum logic [1:0] {
        BPS_RUN = 2'h1,
        BPS_RECOV = 2'h2
    } bps_state_t;
endpackage: bps_pkg

// ---- design/bps_ras_if.sv ----
/*
 * Port bundle between the branch control unit and its return stack.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
interface bps_ras_if #(parameter int AW = bps_pkg::BPS_AW) ();
    logic push;
    logic pop;
    logic [AW-1:0] push_addr;
    logic [AW-1:0] top_addr;
    logic top_valid;
    modport stack (input push, pop, push_addr, output top_addr, top_valid);
    modport user (output push, pop, push_addr, input top_addr, top_valid);
endinterface: bps_ras_if

// ---- design/bps_ras.sv ----
/*
 * Circular return address stack.
 * Assumes push and pop never arrive in the same cycle.
 */
`timescale 1ns/1ns
module bps_ras import bps_pkg::*; #(
    parameter int AW = BPS_AW,
    parameter int DEPTH = BPS_RAS_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Stack port
    bps_ras_if.stack rif
);
    localparam int PW = $clog2(DEPTH);
    logic [AW-1:0] mem [DEPTH];
    logic [PW-1:0] ptr;
    logic [PW:0] cnt;
    wire [PW-1:0] top_idx = ptr - 1'b1;
    wire full = cnt == (PW+1)'(DEPTH);

    assign rif.top_addr = mem[top_idx];
    assign rif.top_valid = cnt != '0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ptr <= '0;
            cnt <= '0;
        end
        else if (rif.push)
        begin
            mem[ptr] <= rif.push_addr;
            ptr <= ptr + 1'b1;
            if (!full)
            begin
                cnt <= cnt + 1'b1;
            end
        end
        else if (rif.pop && rif.top_valid)
        begin
            ptr <= top_idx;
            cnt <= cnt - 1'b1;
        end
    end

    AST_RAS_FULL_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        rif.push && full |=> cnt == (PW+1)'(DEPTH) && ptr == $past(ptr) + 1'b1)
        else $error("Push on a full stack did not overwrite the oldest entry.");
    AST_RAS_POP: assert property (@(posedge clk_i) disable iff (rst_i)
        rif.pop && !rif.push && rif.top_valid |=> cnt == $past(cnt) - 1'b1)
        else $error("Pop did not shrink the stack.");
endmodule: bps_ras

// ---- design/bps_branch_ctrl.sv ----
/*
 * Branch prediction, misprediction recovery and speculation tracking.
 * Assumes fetch, decode and execute logic on the same clock, branches
 * resolving in program order through the X pipe.
 */
`timescale 1ns/1ns
module bps_branch_ctrl import bps_pkg::*; #(
    parameter int AW = BPS_AW,
    parameter int ENTRIES = BPS_BTB_ENTRIES,
    parameter int WAYS = BPS_BTB_WAYS,
    parameter int RAS_DEPTH = BPS_RAS_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fetch stage
    input wire logic fetch_valid_i,
    input wire bps_kind_t fetch_kind_i,
    input wire logic [AW-1:0] fetch_pc_i,
    input wire logic [AW-1:0] fetch_seq_i,
    output logic fetch_redir_o,
    output logic [AW-1:0] fetch_addr_o,
    output logic fetch_taken_o,
    output logic [AW-1:0] fetch_alt_o,
    // Decode and issue
    input wire logic dec_valid_i,
    input wire logic dec_cond_i,
    input wire logic dec_fp_i,
    input wire logic dec_nonckpt_i,
    input wire logic dec_taken_i,
    input wire logic [AW-1:0] dec_pc_i,
    input wire logic [AW-1:0] dec_seq_i,
    output logic issue_stall_o,
    output logic issue_x_only_o,
    output logic ckpt_save_o,
    output logic [1:0] ckpt_slot_o,
    // Unconditional target learning
    input wire logic learn_valid_i,
    input wire logic [AW-1:0] learn_pc_i,
    input wire logic [AW-1:0] learn_target_i,
    // Execute results
    input wire logic ex_valid_i,
    input wire logic [1:0] ex_slot_i,
    input wire logic ex_taken_i,
    input wire logic [AW-1:0] ex_target_i,
    input wire logic ex_cc_parallel_i,
    input wire logic fp_done_i,
    input wire logic [1:0] fp_slot_i,
    // Halt conditions
    input wire logic exc_i,
    input wire logic wbuf_full_i,
    // Recovery and speculation status
    output logic flush_o,
    output logic restore_o,
    output logic [1:0] restore_slot_o,
    output logic [3:0] ckpt_release_o,
    output logic [2:0] spec_level_o,
    output logic spec_halt_o,
    output logic wr_hold_o
);
    localparam int SETS = ENTRIES / WAYS;
    localparam int SW = $clog2(SETS);
    localparam int WW = $clog2(WAYS);
    localparam int SLOTS = BPS_SPEC_MAX;
    localparam int SLW = $clog2(SLOTS);
    localparam logic [2:0] LVL_MAX = 3'(BPS_SPEC_MAX);

    function automatic logic [WW-1:0] first_set(input logic [WAYS-1:0] v);
        first_set = '0;
        for (int i = WAYS - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                first_set = WW'(i);
            end
        end
    endfunction: first_set

    function automatic logic [2:0] ones(input logic [SLOTS-1:0] v);
        ones = '0;
        for (int i = 0; i < SLOTS; i++)
        begin
            ones = ones + 3'(v[i]);
        end
    endfunction: ones

    logic [WAYS-1:0] vld [SETS];
    logic [AW-SW-1:0] tag [SETS][WAYS];
    logic [AW-1:0] tgt [SETS][WAYS];
    logic [1:0] ctr [SETS][WAYS];
    logic [WW-1:0] rr [SETS];
    logic [SLOTS-1:0] s_vld;
    logic [SLOTS-1:0] s_taken;
    logic [AW-1:0] s_pc [SLOTS];
    logic [AW-1:0] s_seq [SLOTS];
    logic [SLW-1:0] tail;
    logic [2:0] level;
    logic wb_vld;
    logic [SLW-1:0] wb_slot;
    logic wb_taken;
    logic [AW-1:0] wb_tgt;
    bps_state_t state;
    logic [2:0] cnt;
    bps_ras_if #(.AW(AW)) ras_if ();

    // Target buffer lookup for the fetch address and for the update address.
    logic [WAYS-1:0] f_hitv;
    logic [WAYS-1:0] u_hitv;
    wire [SW-1:0] f_set = fetch_pc_i[SW-1:0];
    wire r_ok;
    wire [SLW-1:0] r_slot = wb_vld ? wb_slot : ex_slot_i;
    wire [AW-1:0] u_pc = r_ok ? s_pc[r_slot] : learn_pc_i;
    wire [SW-1:0] u_set = u_pc[SW-1:0];
    for (genvar w = 0; w < WAYS; w++)
    begin : g_way
        assign f_hitv[w] = vld[f_set][w] && tag[f_set][w] == fetch_pc_i[AW-1:SW];
        assign u_hitv[w] = vld[u_set][w] && tag[u_set][w] == u_pc[AW-1:SW];
    end
    wire f_hit = |f_hitv;
    wire [WW-1:0] f_way = first_set(f_hitv);
    wire [AW-1:0] f_tgt = tgt[f_set][f_way];
    wire f_ctr_taken = ctr[f_set][f_way][1];

    // Fetch side prediction.
    wire mis;
    wire is_jmp = fetch_kind_i == BPS_K_JMP || fetch_kind_i == BPS_K_CALL;
    wire is_jcc = fetch_kind_i == BPS_K_JCC;
    wire is_ret = fetch_kind_i == BPS_K_RET;
    wire ras_hit = is_ret && ras_if.top_valid;
    wire f_taken = (is_jmp && f_hit)
        || (is_jcc && f_hit && f_ctr_taken)
        || ras_hit || (is_ret && f_hit);
    wire [AW-1:0] f_addr = ras_hit ? ras_if.top_addr : f_tgt;
    wire [AW-1:0] f_alt = f_taken ? fetch_seq_i : (f_hit ? f_tgt : fetch_seq_i);
    assign ras_if.push = fetch_valid_i && fetch_kind_i == BPS_K_CALL && !mis;
    assign ras_if.pop = fetch_valid_i && is_ret && !mis;
    assign ras_if.push_addr = fetch_seq_i;

    // Resolution: writeback entries are older and go first.
    wire r_vld = wb_vld || (ex_valid_i && !ex_cc_parallel_i);
    wire r_taken = wb_vld ? wb_taken : ex_taken_i;
    wire [AW-1:0] r_tgt = wb_vld ? wb_tgt : ex_target_i;
    assign r_ok = r_vld && s_vld[r_slot];
    assign mis = r_ok && r_taken != s_taken[r_slot];
    wire [AW-1:0] good_addr = r_taken ? r_tgt : s_seq[r_slot];
    wire to_wb = ex_valid_i && (ex_cc_parallel_i || wb_vld) && !mis;

    // Speculation slots, allocated in ring order at the tail.
    wire recov = state == BPS_RECOV;
    wire need = dec_cond_i || dec_fp_i;
    wire halt_now = exc_i || wbuf_full_i
        || (dec_valid_i && dec_nonckpt_i && level != BPS_LEVEL_RST)
        || (dec_valid_i && need && (level == LVL_MAX || s_vld[tail]));
    wire alloc = dec_valid_i && need && !halt_now && !recov && !mis;
    wire [SLW:0] d_tail = tail == r_slot ? (SLW+1)'(SLOTS) : {1'b0, tail - r_slot};
    logic [SLOTS-1:0] rel;
    logic [SLOTS-1:0] kill;
    logic [SLOTS-1:0] al;
    for (genvar j = 0; j < SLOTS; j++)
    begin : g_slot
        assign rel[j] = (r_ok && !mis && r_slot == SLW'(j))
            || (fp_done_i && fp_slot_i == SLW'(j));
        assign kill[j] = mis && {1'b0, SLW'(j) - r_slot} < d_tail;
        assign al[j] = alloc && tail == SLW'(j);
    end
    wire [SLOTS-1:0] next_vld = (s_vld & ~rel & ~kill) | al;
    wire [2:0] next_level = ones(next_vld);
    wire next_recov = mis || (recov && cnt != 3'h0);
    wire next_stall = next_recov || next_level == LVL_MAX || exc_i
        || wbuf_full_i || (dec_valid_i && dec_nonckpt_i && next_level != BPS_LEVEL_RST);

    // Target buffer update from resolution or from learned jumps.
    wire u_en = r_ok || learn_valid_i;
    wire u_taken = r_ok ? r_taken : 1'b1;
    wire [AW-1:0] u_tgt = r_ok ? r_tgt : learn_target_i;
    wire u_hit = |u_hitv;
    wire [WW-1:0] u_way = u_hit ? first_set(u_hitv)
        : (&vld[u_set] ? rr[u_set] : first_set(~vld[u_set]));
    wire [1:0] u_old = ctr[u_set][u_way];
    wire [1:0] u_new = !u_hit ? (r_ok ? BPS_WT : BPS_ST)
        : (u_taken ? (u_old == BPS_ST ? u_old : u_old + 2'h1)
        : (u_old == BPS_SNT ? u_old : u_old - 2'h1));
    wire u_wr = u_en && (u_hit || u_taken);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int s = 0; s < SETS; s++)
            begin
                vld[s] <= '0;
                rr[s] <= '0;
            end
        end
        else if (u_wr)
        begin
            vld[u_set][u_way] <= 1'b1;
            tag[u_set][u_way] <= u_pc[AW-1:SW];
            ctr[u_set][u_way] <= u_new;
            if (u_taken)
            begin
                tgt[u_set][u_way] <= u_tgt;
            end
            if (!u_hit)
            begin
                rr[u_set] <= rr[u_set] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (alloc)
        begin
            s_pc[tail] <= dec_pc_i;
            s_seq[tail] <= dec_seq_i;
            s_taken[tail] <= dec_taken_i && !dec_fp_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_vld <= '0;
            tail <= '0;
            level <= BPS_LEVEL_RST;
            wb_vld <= 1'b0;
            state <= BPS_RUN;
            cnt <= 3'h0;
        end
        else
        begin
            s_vld <= next_vld;
            tail <= mis ? r_slot + 1'b1 : tail + SLW'(alloc);
            level <= next_level;
            wb_vld <= to_wb;
            state <= next_recov ? BPS_RECOV : BPS_RUN;
            cnt <= mis ? (wb_vld ? BPS_PEN_WB : BPS_PEN_EX) - 3'h1 : cnt - 3'(recov);
        end
    end

    always_ff @(posedge clk_i)
    begin
        wb_slot <= ex_slot_i;
        wb_taken <= ex_taken_i;
        wb_tgt <= ex_target_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fetch_redir_o <= 1'b0;
            fetch_addr_o <= '0;
            fetch_taken_o <= 1'b0;
            fetch_alt_o <= '0;
            issue_stall_o <= 1'b0;
            issue_x_only_o <= 1'b0;
            ckpt_save_o <= 1'b0;
            ckpt_slot_o <= '0;
            flush_o <= 1'b0;
            restore_o <= 1'b0;
            restore_slot_o <= '0;
            ckpt_release_o <= '0;
            spec_level_o <= BPS_LEVEL_RST;
            spec_halt_o <= 1'b0;
            wr_hold_o <= 1'b0;
        end
        else
        begin
            fetch_redir_o <= mis || (fetch_valid_i && f_taken);
            fetch_addr_o <= mis ? good_addr : f_addr;
            fetch_taken_o <= fetch_valid_i && f_taken && !mis;
            fetch_alt_o <= f_alt;
            issue_stall_o <= next_stall;
            issue_x_only_o <= dec_valid_i && dec_cond_i;
            ckpt_save_o <= alloc;
            ckpt_slot_o <= tail;
            flush_o <= mis;
            restore_o <= mis;
            restore_slot_o <= r_slot;
            ckpt_release_o <= rel | kill;
            spec_level_o <= next_level;
            spec_halt_o <= halt_now;
            wr_hold_o <= next_level != BPS_LEVEL_RST;
        end
    end

    bps_ras #(.AW(AW), .DEPTH(RAS_DEPTH)) u_ras (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rif(ras_if.stack)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_JMP_HIT: assert property (fetch_valid_i && is_jmp && f_hit && !mis
        |=> fetch_redir_o && fetch_addr_o == $past(f_tgt))
        else $error("Jump hit did not redirect to the buffered target.");
    AST_JCC_HIST: assert property (fetch_valid_i && is_jcc && f_hit && !mis
        |=> fetch_taken_o == $past(f_ctr_taken))
        else $error("Conditional hit ignored the stored history.");
    AST_JCC_MISS: assert property (fetch_valid_i && is_jcc && !f_hit && !mis
        |=> !fetch_redir_o && fetch_alt_o == $past(fetch_seq_i))
        else $error("Conditional miss was not predicted not taken.");
    AST_X_ONLY: assert property (dec_valid_i && dec_cond_i |=> issue_x_only_o)
        else $error("Conditional branch not steered to the X pipe.");
    AST_WB_DELAY: assert property (ex_valid_i && ex_cc_parallel_i && !mis
        |=> wb_vld && wb_slot == $past(ex_slot_i))
        else $error("Parallel flag setter did not defer resolution.");
    AST_GOOD_ONE: assert property (r_ok && !mis |=> !flush_o && !recov)
        else $error("Correct prediction disturbed the pipeline.");
    AST_MIS_REFETCH: assert property (mis |=> flush_o && restore_o
        && fetch_redir_o && fetch_addr_o == $past(good_addr))
        else $error("Misprediction did not flush and refetch.");
    AST_PEN_EX: assert property (mis && !wb_vld
        |=> (state == BPS_RECOV)[*4] ##1 state == BPS_RUN)
        else $error("Execute stage recovery is not four cycles.");
    AST_PEN_WB: assert property (mis && wb_vld
        |=> (state == BPS_RECOV)[*5] ##1 state == BPS_RUN)
        else $error("Writeback stage recovery is not five cycles.");
    AST_LEVEL_MAX: assert property (spec_level_o <= LVL_MAX)
        else $error("Speculation level beyond its limit.");
    AST_LEVEL_INC: assert property (alloc && !r_ok && !fp_done_i
        |=> spec_level_o == $past(level) + 3'h1 && ckpt_save_o)
        else $error("Checkpoint did not raise the level.");
    AST_LEVEL_DEC: assert property (r_ok && !mis && !alloc && !fp_done_i
        |=> spec_level_o == $past(level) - 3'h1)
        else $error("Resolution did not lower the level.");
    AST_WR_HOLD: assert property (wr_hold_o == (spec_level_o != 3'h0))
        else $error("Speculative writes not held back.");
    AST_HALT_FULL: assert property (level == LVL_MAX
        |-> !alloc ##1 (issue_stall_o || $past(rel) != '0))
        else $error("Speculation went past level four.");

    CVR_MIS_WB: cover property (mis && wb_vld);
    CVR_LEVEL_FULL: cover property (spec_level_o == LVL_MAX);
    CVR_RET_STACK: cover property (fetch_valid_i && ras_hit);
endmodule: bps_branch_ctrl

// ---- tb/bps_fpu_model.sv ----
/*
 * Floating point completion model for the branch control bench.
 * Assumes the bench pulses start_i in the cycle an FP op takes a checkpoint.
 */
`timescale 1ns/1ns
module bps_fpu_model #(
    parameter int LAT = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Dispatch side
    input wire logic start_i,
    input wire logic [1:0] slot_i,
    // Completion side
    output logic done_o,
    output logic [1:0] slot_o
);
    int cnt;
    logic [1:0] slot;
    // The slot lines show the inverse of the held slot outside a completion.
    assign slot_o = done_o ? slot : ~slot;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 0;
            slot <= 2'h0;
        end
        else if (start_i)
        begin
            cnt <= LAT;
            slot <= slot_i;
        end
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
        end
        done_o <= !rst_i && !start_i && cnt == 1;
    end
endmodule: bps_fpu_model

// ---- tb/testbench.sv ----
/*
 * Self-checking bench of the branch control unit.
 * Assumes a 100 MHz core clock and inputs driven at the falling edge.
 */
`timescale 1ns/1ns
module testbench import bps_pkg::*;;
    logic clk_i = 0;
    logic rst_i = 1;
    logic fetch_valid_i, dec_valid_i, dec_cond_i, dec_fp_i, dec_nonckpt_i, dec_taken_i;
    logic learn_valid_i, ex_valid_i, ex_taken_i, ex_cc_parallel_i, fp_done_i, exc_i;
    logic wbuf_full_i, fetch_redir_o, fetch_taken_o, issue_stall_o, issue_x_only_o;
    logic ckpt_save_o, flush_o, restore_o, spec_halt_o, wr_hold_o, fp_mode;
    bps_kind_t fetch_kind_i;
    logic [BPS_AW-1:0] fetch_pc_i, fetch_seq_i, dec_pc_i, dec_seq_i, learn_pc_i;
    logic [BPS_AW-1:0] learn_target_i, ex_target_i, fetch_addr_o, fetch_alt_o;
    logic [1:0] ex_slot_i, fp_slot_i, ckpt_slot_o, restore_slot_o;
    logic [3:0] ckpt_release_o;
    logic [2:0] spec_level_o;
    int fail_count = 0;
    int checks_done = 0;

    always #5 clk_i = ~clk_i;

    bps_branch_ctrl i_bps_branch_ctrl (.clk_i, .rst_i, .fetch_valid_i, .fetch_kind_i,
        .fetch_pc_i, .fetch_seq_i, .fetch_redir_o, .fetch_addr_o, .fetch_taken_o,
        .fetch_alt_o, .dec_valid_i, .dec_cond_i, .dec_fp_i, .dec_nonckpt_i, .dec_taken_i,
        .dec_pc_i, .dec_seq_i, .issue_stall_o, .issue_x_only_o, .ckpt_save_o, .ckpt_slot_o,
        .learn_valid_i, .learn_pc_i, .learn_target_i, .ex_valid_i, .ex_slot_i, .ex_taken_i,
        .ex_target_i, .ex_cc_parallel_i, .fp_done_i, .fp_slot_i, .exc_i, .wbuf_full_i,
        .flush_o, .restore_o, .restore_slot_o, .ckpt_release_o, .spec_level_o,
        .spec_halt_o, .wr_hold_o);

    bps_fpu_model i_bps_fpu_model (.clk_i, .rst_i, .start_i(ckpt_save_o & fp_mode),
        .slot_i(ckpt_slot_o), .done_o(fp_done_i), .slot_o(fp_slot_i));

    task automatic summarize;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask: summarize

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask: chk

    task automatic fe(input bps_kind_t k, input logic [31:0] pc, input logic [31:0] seq);
        @(negedge clk_i);
        fetch_valid_i = 1;
        fetch_kind_i = k;
        fetch_pc_i = pc;
        fetch_seq_i = seq;
        @(negedge clk_i);
        fetch_valid_i = 0;
    endtask: fe

    task automatic dec(input logic c, input logic fp, input logic nc, input logic tk,
        input logic [31:0] seq);
        @(negedge clk_i);
        dec_valid_i = 1;
        dec_cond_i = c;
        dec_fp_i = fp;
        dec_nonckpt_i = nc;
        dec_taken_i = tk;
        dec_seq_i = seq;
        dec_pc_i = seq - 32'h0000_0004;
        @(negedge clk_i);
        dec_valid_i = 0;
    endtask: dec

    task automatic ex(input logic [1:0] s, input logic tk, input logic par,
        input logic [31:0] tgt);
        @(negedge clk_i);
        ex_valid_i = 1;
        ex_slot_i = s;
        ex_taken_i = tk;
        ex_cc_parallel_i = par;
        ex_target_i = tgt;
        @(negedge clk_i);
        ex_valid_i = 0;
    endtask: ex

    task automatic t_fetch;
        @(negedge clk_i);
        learn_valid_i = 1;
        learn_pc_i = 32'h0000_1040;
        learn_target_i = 32'h0000_8000;
        @(negedge clk_i);
        learn_valid_i = 0;
        fe(BPS_K_JMP, 32'h0000_1040, 32'h0000_1044);
        chk(fetch_redir_o === 1 && fetch_addr_o === 32'h0000_8000, "jmp redirect");
        chk(fetch_taken_o === 1 && fetch_alt_o === 32'h0000_1044, "jmp alt path");
        fe(BPS_K_JCC, 32'h0000_1040, 32'h0000_1044);
        chk(fetch_redir_o === 1 && fetch_addr_o === 32'h0000_8000, "jcc hit");
        chk(fetch_alt_o === 32'h0000_1044, "jcc alt path");
        fe(BPS_K_JCC, 32'h0000_2000, 32'h0000_2004);
        chk(fetch_redir_o === 0 && fetch_taken_o === 0, "jcc miss");
        fe(BPS_K_NONE, 32'h0000_1040, 32'h0000_1044);
        chk(fetch_redir_o === 0, "plain instruction");
        $display("test fetch done");
    endtask: t_fetch

    task automatic t_ras;
        for (int i = 0; i < 9; i++)
            fe(BPS_K_CALL, 32'h0000_3000 + i * 64, 32'h0000_4000 + i * 4);
        for (int i = 8; i > 0; i--)
        begin
            fe(BPS_K_RET, 32'h0000_5000, 32'h0000_5004);
            chk(fetch_redir_o === 1 && fetch_addr_o === 32'h0000_4000 + i * 4, "ret");
        end
        fe(BPS_K_RET, 32'h0000_5000, 32'h0000_5004);
        chk(fetch_redir_o === 0, "empty stack ret");
        $display("test return stack done");
    endtask: t_ras

    task automatic t_spec;
        logic [1:0] sl[4];
        for (int i = 0; i < 4; i++)
        begin
            dec(1, 0, 0, 0, 32'h0000_6000 + i * 16);
            chk(ckpt_save_o === 1 && issue_x_only_o === 1, "checkpoint");
            chk(spec_level_o === 3'(i + 1) && wr_hold_o === 1, "level up");
            sl[i] = ckpt_slot_o;
        end
        dec(1, 0, 0, 0, 32'h0000_6040);
        chk(ckpt_save_o === 0 && spec_halt_o === 1, "fifth level");
        chk(issue_stall_o === 1 && spec_level_o === 3'h4, "stall at limit");
        for (int i = 0; i < 4; i++)
        begin
            ex(sl[i], 0, 0, 32'h0000_9000);
            chk(ckpt_release_o[sl[i]] === 1 && flush_o === 0, "release");
            chk(spec_level_o === 3'(3 - i), "level down");
        end
        chk(wr_hold_o === 0 && issue_stall_o === 0, "idle after resolve");
        $display("test speculation done");
    endtask: t_spec

    task automatic t_misp(input logic par);
        logic [1:0] s;
        logic [31:0] exp;
        int n;
        dec(1, 0, 0, par, 32'h0000_7000);
        s = ckpt_slot_o;
        exp = par ? 32'h0000_7000 : 32'h0000_9000;
        ex(s, !par, par, 32'h0000_9000);
        for (n = 0; n < 3 && flush_o !== 1; n++)
            @(negedge clk_i);
        chk(n == (par ? 1 : 0), "resolve stage");
        chk(restore_o === 1 && restore_slot_o === s, "restore");
        chk(fetch_redir_o === 1 && fetch_addr_o === exp && fetch_taken_o === 0, "refetch");
        for (n = 0; n < 9 && issue_stall_o === 1; n++)
            @(negedge clk_i);
        chk(n == (par ? 5 : 4), "recovery length");
        chk(spec_level_o === 3'h0, "level after flush");
        $display("test mispredict done");
    endtask: t_misp

    task automatic t_halt;
        logic [1:0] fs;
        int n;
        fp_mode = 1;
        dec(0, 1, 0, 0, 32'h0000_A000);
        fs = ckpt_slot_o;
        chk(ckpt_save_o === 1 && spec_level_o === 3'h1, "fp checkpoint");
        dec(0, 0, 1, 0, 32'h0000_A010);
        fp_mode = 0;
        chk(ckpt_save_o === 0 && spec_halt_o === 1, "unsaved resource");
        for (n = 0; n < 12 && ckpt_release_o === 4'h0; n++)
            @(negedge clk_i);
        chk(ckpt_release_o === 4'h1 << fs && spec_level_o === 3'h0, "fp done");
        for (int c = 0; c < 2; c++)
        begin
            exc_i = c == 0;
            wbuf_full_i = c == 1;
            dec(1, 0, 0, 0, 32'h0000_B000);
            chk(ckpt_save_o === 0 && spec_halt_o === 1, "halt cause");
            exc_i = 0;
            wbuf_full_i = 0;
        end
        repeat (3) @(negedge clk_i);
        $display("test halt done");
    endtask: t_halt

    initial
    begin
        {fetch_valid_i, dec_valid_i, dec_cond_i, dec_fp_i, dec_nonckpt_i, dec_taken_i} = 0;
        {learn_valid_i, ex_valid_i, ex_taken_i, ex_cc_parallel_i, exc_i, wbuf_full_i} = 0;
        {fetch_pc_i, fetch_seq_i, dec_pc_i, dec_seq_i, learn_pc_i, learn_target_i} = 0;
        {ex_target_i, ex_slot_i, fp_mode} = 0;
        fetch_kind_i = BPS_K_NONE;
        repeat (6) @(negedge clk_i);
        rst_i = 0;
        chk(spec_level_o === 3'h0 && wr_hold_o === 0 && flush_o === 0, "reset state");
        t_fetch();
        t_ras();
        t_spec();
        t_misp(0);
        t_misp(1);
        t_halt();
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        summarize();
    end
endmodule: testbench
